// *** rtl/dual_pot_device.sv ***
// Contract
// - First byte: address, upper nibble type code
// - Execute only if low bits match straps
// - Host sends zeros in bits 3:2
// - Second byte upper nibble is opcode
// - Instruction bits 3:2 select slot
// - Instruction bits 1:0 select pot; code decodes bit 0 only, bit 1 ignored
// - Wiper value decoded one-hot, 256 taps
// - Wiper set by write, copy, step
// - Power-up loads wiper from slot zero
// - Wiper volatile, reloaded after power-up
// - Four 8-bit slots per pot, read/write
// - Copy slot and wiper both ways
// - Slot programming completes within 5ms
// - Programming starts at chip select rise
// - Write pending flag readable by status
// - Tap changes 5-10us after instruction
// - Tap takes recalled position 5-10us
// - Host waits 1ms after power-up
// - Flag one while programming, else zero
// - Inc/dec: each clock steps by SI
`include "dual_pot_regs.svh"
module dual_pot_device #(
  parameter int PROG_CYCLES   = `PROG_CYCLES,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire logic           clk_en,
  // Link
  dual_pot_link_if.device     link,
  // Tap outputs
  output logic [255:0]        tap0,
  output logic [255:0]        tap1,
  output logic                write_pending_flag
);
  import dual_pot_pkg::*;

  typedef enum logic [2:0] {
    ST_RECALL = 3'b000,
    ST_ADDR   = 3'b001,
    ST_INSTR  = 3'b010,
    ST_DATA   = 3'b011,
    ST_STEP   = 3'b100,
    ST_SKIP   = 3'b101
  } dev_state_e;

  logic cs_n_s, sck_s, si_s, a1_s, a0_s;
  pin_sync #(.RESET_LEVEL(1'b1)) u_cs (.mclk(mclk), .reset(reset), .clk_en(clk_en),
                                       .pin(link.chip_sel_n), .level(cs_n_s));
  pin_sync u_sck (.mclk(mclk), .reset(reset), .clk_en(clk_en), .pin(link.sck),
                  .level(sck_s));
  pin_sync u_si (.mclk(mclk), .reset(reset), .clk_en(clk_en), .pin(link.si),
                 .level(si_s));
  pin_sync u_a1 (.mclk(mclk), .reset(reset), .clk_en(clk_en), .pin(link.strap_addr_high),
                 .level(a1_s));
  pin_sync u_a0 (.mclk(mclk), .reset(reset), .clk_en(clk_en), .pin(link.strap_addr_low),
                 .level(a0_s));

  logic sck_prev_q, cs_prev_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else if (clk_en) begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end
  wire sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
  wire cs_rise  = cs_n_s & ~cs_prev_q;

  // Non-volatile slots survive reset; only power loss is modelled by reset of the wiper
  byte_t slot_mem [2][4];
  byte_t wiper_position_reg [2];

  dev_state_e state_q;
  logic [2:0] bit_q;
  byte_t      shift_q, instr_q, out_q;
  logic       pend_prog_q;
  logic [1:0] pend_pot_q, pend_slot_q;
  logic       pend_all_q;
  byte_t      pend_val_q [2];
  logic [31:0] prog_cnt_q;
  logic [31:0] settle_cnt_q;
  byte_t      tap_sel_q [2];

  wire byte_t   shift_d  = {shift_q[6:0], si_s};
  wire opcode_t opc      = instr_q[7:4];
  wire [1:0]    slot_sel = instr_q[3:2];
  wire          pot      = instr_q[0];
  wire          prog_busy = (prog_cnt_q != 32'd0);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q      <= ST_RECALL;
      bit_q        <= 3'd0;
      shift_q      <= 8'h00;
      instr_q      <= 8'h00;
      out_q        <= 8'h00;
      pend_prog_q  <= 1'b0;
      pend_pot_q   <= 2'd0;
      pend_slot_q  <= 2'd0;
      pend_all_q   <= 1'b0;
      pend_val_q   <= '{8'h00, 8'h00};
      wiper_position_reg <= '{8'h00, 8'h00};
    end else if (clk_en) begin
      if (state_q == ST_RECALL) begin
        wiper_position_reg[0] <= slot_mem[0][0];
        wiper_position_reg[1] <= slot_mem[1][0];
        state_q  <= ST_ADDR;
      end else if (cs_n_s) begin
        state_q <= ST_ADDR;
        bit_q   <= 3'd0;
      end else if (sck_rise) begin
        shift_q <= shift_d;
        bit_q   <= bit_q + 3'd1;
        case (state_q)
          ST_ADDR: if (bit_q == 3'd7) begin
            state_q <= (shift_d[7:4] == `DEV_TYPE_CODE
                        && shift_d[1:0] == {a1_s, a0_s}) ? ST_INSTR : ST_SKIP;
          end
          ST_INSTR: if (bit_q == 3'd7) begin
            instr_q <= shift_d;
            state_q <= ST_DATA;
            case (shift_d[7:4])
              `OPC_READ_WIPER:  out_q <= wiper_position_reg[shift_d[0]];
              `OPC_READ_SLOT:   out_q <= slot_mem[shift_d[0]][shift_d[3:2]];
              `OPC_READ_STATUS: out_q <= {7'd0, prog_busy};
              `OPC_SLOT_TO_WIPER:
                wiper_position_reg[shift_d[0]] <= slot_mem[shift_d[0]][shift_d[3:2]];
              `OPC_GLOBAL_TO_WIPER: begin
                wiper_position_reg[0] <= slot_mem[0][shift_d[3:2]];
                wiper_position_reg[1] <= slot_mem[1][shift_d[3:2]];
              end
              `OPC_WIPER_TO_SLOT, `OPC_GLOBAL_TO_SLOT: if (!prog_busy) begin
                pend_prog_q <= 1'b1;
                pend_all_q  <= (shift_d[7:4] == `OPC_GLOBAL_TO_SLOT);
                pend_pot_q  <= {1'b0, shift_d[0]};
                pend_slot_q <= shift_d[3:2];
                pend_val_q  <= wiper_position_reg;
              end
              `OPC_INC_DEC: state_q <= ST_STEP;
              default: ;
            endcase
          end
          ST_DATA: if (bit_q == 3'd7) begin
            case (opc)
              `OPC_WRITE_WIPER: wiper_position_reg[pot] <= shift_d;
              `OPC_WRITE_SLOT: if (!prog_busy) begin
                pend_prog_q <= 1'b1;
                pend_all_q  <= 1'b0;
                pend_pot_q  <= {1'b0, pot};
                pend_slot_q <= slot_sel;
                pend_val_q[pot] <= shift_d;
              end
              default: ;
            endcase
          end
          ST_STEP: begin
            // Saturate at the terminals rather than wrap
            if (si_s && wiper_position_reg[pot] != 8'hff) begin
              wiper_position_reg[pot] <= wiper_position_reg[pot] + 8'd1;
            end else if (!si_s && wiper_position_reg[pot] != 8'h00) begin
              wiper_position_reg[pot] <= wiper_position_reg[pot] - 8'd1;
            end
          end
          default: ;
        endcase
      end else if (sck_fall && state_q == ST_DATA) begin
        out_q <= {out_q[6:0], 1'b0};
      end
      if (cs_rise && pend_prog_q) begin
        pend_prog_q <= 1'b0;
      end
    end
  end

  // Programming launched only by chip select rise
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prog_cnt_q <= 32'd0;
    end else if (clk_en) begin
      if (cs_rise && pend_prog_q) begin
        prog_cnt_q <= PROG_CYCLES[31:0];
      end else if (prog_busy) begin
        prog_cnt_q <= prog_cnt_q - 32'd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clk_en && cs_rise && pend_prog_q) begin
      if (pend_all_q) begin
        slot_mem[0][pend_slot_q] <= pend_val_q[0];
        slot_mem[1][pend_slot_q] <= pend_val_q[1];
      end else begin
        slot_mem[pend_pot_q[0]][pend_slot_q] <= pend_val_q[pend_pot_q[0]];
      end
    end
  end

  // Tap follows the wiper after a settle delay
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      settle_cnt_q <= 32'd0;
      tap_sel_q    <= '{8'h00, 8'h00};
    end else if (clk_en) begin
      if (tap_sel_q[0] != wiper_position_reg[0] || tap_sel_q[1] != wiper_position_reg[1]) begin
        if (settle_cnt_q >= SETTLE_CYCLES[31:0] - 32'd1) begin
          tap_sel_q    <= wiper_position_reg;
          settle_cnt_q <= 32'd0;
        end else begin
          settle_cnt_q <= settle_cnt_q + 32'd1;
        end
      end else begin
        settle_cnt_q <= 32'd0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tap0 <= 256'd0;
      tap1 <= 256'd0;
      write_pending_flag <= 1'b0;
      link.so    <= 1'b0;
      link.so_oe <= 1'b0;
    end else if (clk_en) begin
      tap0 <= 256'd1 << tap_sel_q[0];
      tap1 <= 256'd1 << tap_sel_q[1];
      write_pending_flag <= prog_busy;
      link.so    <= out_q[7];
      link.so_oe <= ~cs_n_s && state_q == ST_DATA &&
                    (opc == `OPC_READ_WIPER || opc == `OPC_READ_SLOT ||
                     opc == `OPC_READ_STATUS);
    end
  end
endmodule

// *** rtl/dual_pot_host.sv ***
`include "dual_pot_regs.svh"
module dual_pot_host #(
  parameter int POWERUP_CYCLES = `POWERUP_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  dual_pot_link_if.host    link
);
  import dual_pot_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP   = 2'b10
  } host_state_e;

  logic so_s;
  pin_sync u_so (.mclk(mclk), .reset(reset), .clk_en(clk_en), .pin(link.so), .level(so_s));

  host_state_e state_q;
  logic [23:0] cmd_q;
  byte_t       data_q, result_q;
  logic [5:0]  bits_left_q;
  logic [3:0]  div_q;
  logic [31:0] pu_cnt_q;
  logic [23:0] tx_q;
  byte_t       rx_q;
  logic        start_q;
  logic        keep_sel_q;

  wire ready_pu  = (pu_cnt_q == 32'd0);
  wire busy      = (state_q != H_IDLE);
  wire acc       = psel & penable;
  wire byte_t steps = cmd_q[`CMD_STEPS_LSB +: 8];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pu_cnt_q <= POWERUP_CYCLES[31:0];
    end else if (clk_en && !ready_pu) begin
      pu_cnt_q <= pu_cnt_q - 32'd1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      cmd_q   <= 24'h0;
      data_q  <= 8'h00;
      start_q <= 1'b0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          `REG_CMD:    prdata <= {8'h00, cmd_q};
          `REG_DATA:   prdata <= {24'h0, data_q};
          `REG_STATUS: prdata <= {30'h0, ready_pu, busy};
          `REG_RESULT: prdata <= {24'h0, result_q};
          `REG_CTRL:   prdata <= 32'h0;
          default:     pslverr <= 1'b1;
        endcase
      end
      // Writes land only at the edge that completes the access
      if (acc && pready && pwrite) begin
        case (paddr)
          // Address bits 3:2 forced to zero
          `REG_CMD:  cmd_q  <= {pwdata[23:4], 2'b00, pwdata[1:0]};
          `REG_DATA: data_q <= pwdata[7:0];
          `REG_CTRL: start_q <= pwdata[0] & ~busy & ready_pu;
          default: ;
        endcase
      end
    end
  end

  // Frame: address, instruction, then data byte or step clocks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q     <= H_IDLE;
      link.chip_sel_n <= 1'b1;
      link.sck    <= 1'b0;
      link.si     <= 1'b0;
      bits_left_q <= 6'd0;
      div_q       <= 4'd0;
      tx_q        <= 24'h0;
      rx_q        <= 8'h00;
      result_q    <= 8'h00;
      keep_sel_q  <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        H_IDLE: if (start_q) begin
          state_q <= H_SHIFT;
          link.chip_sel_n <= 1'b0;
          // Address byte then instruction byte, msb first
          tx_q <= {cmd_q[7:0], cmd_q[15:8], data_q};
          keep_sel_q <= (cmd_q[15:12] == `OPC_INC_DEC);
          bits_left_q <= (cmd_q[15:12] == `OPC_INC_DEC) ? 6'd16 + steps[5:0] : 6'd24;
          div_q <= 4'd0;
          link.si <= cmd_q[7];
        end
        H_SHIFT: begin
          div_q <= div_q + 4'd1;
          if (div_q == 4'(`HALF_SCK_CYCLES - 1)) begin
            link.sck <= 1'b1;
            rx_q <= {rx_q[6:0], so_s};
          end else if (div_q == 4'(2 * `HALF_SCK_CYCLES - 1)) begin
            link.sck <= 1'b0;
            div_q <= 4'd0;
            tx_q <= {tx_q[22:0], 1'b0};
            // Inc/dec step direction taken from data bit 7
            link.si <= (keep_sel_q && bits_left_q <= steps[5:0] + 6'd1) ? data_q[7]
                                                                        : tx_q[22];
            if (bits_left_q == 6'd1) begin
              state_q <= H_GAP;
            end
            bits_left_q <= bits_left_q - 6'd1;
          end
        end
        H_GAP: begin
          div_q <= div_q + 4'd1;
          if (div_q == 4'(`HALF_SCK_CYCLES - 1)) begin
            link.chip_sel_n <= 1'b1;
            result_q <= rx_q;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end
endmodule

// *** rtl/dual_pot_link_if.sv ***
interface dual_pot_link_if;
  logic chip_sel_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic strap_addr_high;
  logic strap_addr_low;
  modport device (input chip_sel_n, sck, si, strap_addr_high, strap_addr_low,
                  output so, so_oe);
  modport host   (output chip_sel_n, sck, si, input so, so_oe);
endinterface

// *** rtl/dual_pot_pkg.sv ***
package dual_pot_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] opcode_t;
endpackage

// *** rtl/dual_pot_regs.svh ***
`ifndef DUAL_POT_REGS_SVH
`define DUAL_POT_REGS_SVH
// Device type code; value arbitrary
`define DEV_TYPE_CODE      4'ha
`define OPC_READ_WIPER     4'h9
`define OPC_WRITE_WIPER    4'ha
`define OPC_READ_SLOT      4'hb
`define OPC_WRITE_SLOT     4'hc
`define OPC_SLOT_TO_WIPER  4'hd
`define OPC_WIPER_TO_SLOT  4'he
`define OPC_GLOBAL_TO_WIPER 4'h1
`define OPC_GLOBAL_TO_SLOT 4'h8
`define OPC_INC_DEC        4'h2
`define OPC_READ_STATUS    4'h5
// Times in ns, counts in mclk cycles at 8 ns
`define MCLK_NS            8
`define PROG_TIME_NS       5000000
`define PROG_CYCLES        (`PROG_TIME_NS / `MCLK_NS)
`define SETTLE_MIN_NS      5000
`define SETTLE_MAX_NS      10000
`define SETTLE_CYCLES      ((`SETTLE_MIN_NS + `MCLK_NS - 1) / `MCLK_NS)
`define POWERUP_WAIT_NS    1000000
`define POWERUP_CYCLES     (`POWERUP_WAIT_NS / `MCLK_NS)
// Host register offsets
`define REG_CMD            12'h000
`define REG_DATA           12'h004
`define REG_STATUS         12'h008
`define REG_RESULT         12'h00c
`define REG_CTRL           12'h010
// CMD fields
`define CMD_ADDR_LSB       0
`define CMD_INSTR_LSB      8
`define CMD_STEPS_LSB      16
// Host link clock half period in mclk cycles
`define HALF_SCK_CYCLES    8
`endif

// *** rtl/pin_sync.sv ***
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Pin
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      // Reset to the pin's idle level, so no false edge follows reset
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else if (clk_en) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted once stages two and three agree
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule

// *** test/dual_pot_chk.sv ***
`include "dual_pot_regs.svh"
module dual_pot_chk #(
  parameter int PROG_CYCLES = 2000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link
  input wire logic chip_sel_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic strap_addr_high,
  input wire logic strap_addr_low,
  // Status
  input wire logic write_pending_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sck_q;
  logic [5:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [31:0] prog_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Bits seen on the wire since chip select fell
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
      cnt_q <= 6'h0;
      sh_q  <= 8'h0;
    end else begin
      sck_q <= sck;
      if (chip_sel_n)
        cnt_q <= 6'h0;
      else if (sck && !sck_q) begin
        cnt_q <= cnt_q + 6'h1;
        sh_q  <= {sh_q[6:0], si};
      end
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      prog_q <= 32'h0;
    else
      prog_q <= write_pending_flag ? prog_q + 32'h1 : 32'h0;
  end
  chk_type_code:
    assert property (sck && !sck_q && cnt_q == 6'h3 |=> sh_q[3:0] == `DEV_TYPE_CODE)
    else $error("type nibble wrong");
  chk_pad_zero:
    assert property (sck && !sck_q && cnt_q == 6'h5 |=> sh_q[1:0] == 2'b00)
    else $error("pad bits not zero");
  chk_frame_len:
    assert property ($rose(chip_sel_n) |-> cnt_q >= 6'h10)
    else $error("frame shorter than two bytes");
  chk_si_stable:
    assert property (!chip_sel_n && $rose(sck) |-> $stable(si))
    else $error("data moved at sampling edge");
  chk_flag_start:
    assert property ($rose(write_pending_flag) |-> chip_sel_n)
    else $error("programming began inside a frame");
  chk_flag_hold:
    assert property ($rose(write_pending_flag) |=> write_pending_flag [*8])
    else $error("pending flag dropped early");
  chk_prog_bound:
    assert property (prog_q <= PROG_CYCLES)
    else $error("programming too long");
  chk_so_quiet:
    assert property (chip_sel_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
endmodule

// *** test/tb_dual_pot_serial_command_core.sv ***
`include "dual_pot_regs.svh"
module tb_dual_pot_serial_command_core;
  timeunit 1ns;
  timeprecision 1ps;
  import dual_pot_pkg::*;
  localparam int PROG   = 2000;
  localparam int SETTLE = 20;
  localparam int PWRUP  = 100;
  logic         mclk, reset, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [255:0] tap0, tap1;
  logic         write_pending_flag;
  logic [1:0]   strap, sa;
  byte_t        slot_m [8];
  byte_t        wip_m [2];
  byte_t        exp_q [$];
  byte_t        w, st, d;
  int           t, bad_count, checked;

  dual_pot_link_if link ();
  assign link.strap_addr_high = strap[1];
  assign link.strap_addr_low  = strap[0];
  dual_pot_device #(.PROG_CYCLES(PROG), .SETTLE_CYCLES(SETTLE)) dual_pot_device_inst (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .link(link.device), .tap0(tap0),
    .tap1(tap1), .write_pending_flag(write_pending_flag));
  dual_pot_host #(.POWERUP_CYCLES(PWRUP)) dual_pot_host_inst (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  dual_pot_chk #(.PROG_CYCLES(PROG)) dual_pot_chk_inst (
    .mclk(mclk), .reset(reset), .chip_sel_n(link.chip_sel_n), .sck(link.sck),
    .si(link.si), .so(link.so), .so_oe(link.so_oe),
    .strap_addr_high(link.strap_addr_high), .strap_addr_low(link.strap_addr_low),
    .write_pending_flag(write_pending_flag));

  task automatic cmp8(input byte_t act, input byte_t exp);
    checked++;
    if (act !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cmp_tap(input logic [255:0] act, input byte_t v);
    checked++;
    if (act !== (256'h1 << v)) begin
      bad_count++;
      $display("[FAIL] %0t tap not at %0d", $time, v);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic byte_t ins(input opcode_t op, input int i);
    return {op, i[1:0], 1'b0, i[2]};
  endfunction
  task automatic cmd(input byte_t i, input byte_t dat, input byte_t steps);
    apb(1'b1, `REG_DATA, {24'h0, dat});
    apb(1'b1, `REG_CMD, {8'h0, steps, i, `DEV_TYPE_CODE, 2'b00, sa});
    apb(1'b1, `REG_CTRL, 32'h1);
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
    // Longest wiper settle time
    repeat (2 * SETTLE) @(posedge mclk);
  endtask
  task automatic rdq(input byte_t i, input byte_t e);
    exp_q.push_back(e);
    cmd(i, 8'h0, 8'h0);
    apb(1'b0, `REG_RESULT, 32'h0);
  endtask
  task automatic idle();
    while (write_pending_flag !== 1'b0) begin
      @(posedge mclk);
    end
  endtask
  task automatic powerup();
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
    end while (rd[1] !== 1'b1);
  endtask
  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && paddr == `REG_RESULT)
      cmp8(prdata[7:0], exp_q.pop_front());
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(19552));
    {reset, clk_en, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
    strap = 2'($urandom);
    sa = strap;
    bad_count = 0;
    checked = 0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    cmp8({7'h0, link.chip_sel_n}, 8'h01);
    // A frozen clock enable must stall the power-up count too
    clk_en <= 1'b0;
    repeat (2 * PWRUP) @(posedge mclk);
    clk_en <= 1'b1;
    apb(1'b0, `REG_STATUS, 32'h0);
    cmp8({7'h0, rd[1]}, 8'h00);
    powerup();
    for (int i = 0; i < 8; i++) begin
      slot_m[i] = byte_t'($urandom);
      cmd(ins(`OPC_WRITE_SLOT, i), slot_m[i], 8'h0);
      idle();
    end
    for (int i = 0; i < 8; i++)
      rdq(ins(`OPC_READ_SLOT, i), slot_m[i]);
    $display("test slots done");
    // Both wipers at once, so neither keeps the unknown first recall
    cmd(ins(`OPC_GLOBAL_TO_WIPER, 0), 8'h0, 8'h0);
    cmp_tap(tap0, slot_m[0]);
    cmp_tap(tap1, slot_m[4]);
    for (int p = 0; p < 2; p++) begin
      wip_m[p] = byte_t'($urandom);
      cmd(ins(`OPC_WRITE_WIPER, p * 4), wip_m[p], 8'h0);
      cmp_tap(p ? tap1 : tap0, wip_m[p]);
      rdq(ins(`OPC_READ_WIPER, p * 4), wip_m[p]);
      cmd(ins(`OPC_WIPER_TO_SLOT, p * 4 + 3), 8'h0, 8'h0);
      idle();
      slot_m[p * 4 + 3] = wip_m[p];
      rdq(ins(`OPC_READ_SLOT, p * 4 + 3), slot_m[p * 4 + 3]);
    end
    for (int i = 0; i < 8; i++) begin
      cmd(ins(`OPC_SLOT_TO_WIPER, i), 8'h0, 8'h0);
      cmp_tap(i > 3 ? tap1 : tap0, slot_m[i]);
    end
    cmd(ins(`OPC_GLOBAL_TO_WIPER, 1), 8'h0, 8'h0);
    cmp_tap(tap0, slot_m[1]);
    cmp_tap(tap1, slot_m[5]);
    cmd(ins(`OPC_GLOBAL_TO_SLOT, 2), 8'h0, 8'h0);
    idle();
    slot_m[2] = slot_m[1];
    slot_m[6] = slot_m[5];
    rdq(ins(`OPC_READ_SLOT, 2), slot_m[2]);
    rdq(ins(`OPC_READ_SLOT, 6), slot_m[6]);
    $display("test copies done");
    w = byte_t'($urandom);
    cmd(ins(`OPC_WRITE_SLOT, 5), w, 8'h0);
    rdq(ins(`OPC_READ_STATUS, 4), 8'h01);
    cmd(ins(`OPC_WRITE_SLOT, 5), ~w, 8'h0);
    idle();
    slot_m[5] = w;
    rdq(ins(`OPC_READ_SLOT, 5), w);
    rdq(ins(`OPC_READ_STATUS, 4), 8'h00);
    $display("test pending done");
    wip_m[0] = 8'hf0;
    cmd(ins(`OPC_WRITE_WIPER, 0), wip_m[0], 8'h0);
    for (int k = 0; k < 4; k++) begin
      st = byte_t'($urandom_range(47, 1));
      d = byte_t'($urandom) & 8'h80;
      cmd(ins(`OPC_INC_DEC, 0), d, st);
      t = int'(wip_m[0]) + (d[7] ? int'(st) : -int'(st));
      wip_m[0] = t > 255 ? 8'hff : (t < 0 ? 8'h00 : byte_t'(t));
      cmp_tap(tap0, wip_m[0]);
    end
    $display("test steps done");
    sa = ~strap;
    cmd(ins(`OPC_WRITE_WIPER, 0), ~wip_m[0], 8'h0);
    cmp_tap(tap0, wip_m[0]);
    sa = strap;
    apb(1'b0, 12'h0fc, 32'h0);
    cmp8({7'h0, err}, 8'h01);
    $display("test refusals done");
    cmd(ins(`OPC_WRITE_WIPER, 0), ~slot_m[0], 8'h0);
    cmd(ins(`OPC_WRITE_WIPER, 4), ~slot_m[4], 8'h0);
    reset <= 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (2 * SETTLE + 2) @(posedge mclk);
    cmp_tap(tap0, slot_m[0]);
    cmp_tap(tap1, slot_m[4]);
    powerup();
    rdq(ins(`OPC_READ_WIPER, 4), slot_m[4]);
    $display("test recall done");
    finish_test();
  end
endmodule
